// File: hw/pfpm_manager.sv
// fault supervision and start-up sequencing with Avalon-MM configuration registers
`timescale 1ns/1ns
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// R1 - lockout strap low, open, high select 3 V, 4.5 V, 10.8 V.
// R2 - software lockout threshold, 2.85 V to 16 V, overrides the strap.
// R3 - strap resistor index maps to tabulated threshold, 46.4k to 7.42 V, 100k to 16 V.
// R4 - undervoltage response: ignore, delayed latched shutdown, or shutdown with retry count.
// R5 - default undervoltage response: shut down, re-enable once input recovers.
// R6 - overvoltage above target plus 15 percent drops power good at once.
// R7 - overvoltage response: shutdown with retries, or low side held until restart.
// R8 - default overvoltage response: shut down, resume when fault clears.
// R9 - with external clock, only shutdown response for overvoltage.
// R10 - sample output before ramp; compare with target and overvoltage limit.
// R11 - pre-bias below target: reference starts at pre-bias, drivers on, ramp.
// R12 - pre-bias above target: drivers on, power good at end of soft start.
// R13 - pre-bias above overvoltage limit: no turn-on, overvoltage fault declared.
// R14 - overcurrent: five responses, retry forever, retry N, delay then off, ignore, off.
// R15 - default overcurrent response: shut down, re-enable once cleared.
// R16 - die temperature above limit, reset 125 degC, writable, shuts down.
// R17 - over-temperature offers the same five responses.
// R18 - thermal retry waits delay, restarts only below limit minus 15 degC.
// R19 - default thermal response: shut down, restart once fault gone.
// R20 - retry budgets reload after each successful start.
module pfpm_manager
   import pfpm_pkg::*;
#(
   parameter logic [15:0] TICK_CYCLES_P = 16'(TICK_CYCLES)
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // avalon-mm slave
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // straps and sensed quantities
   input wire logic [1:0] lockoutStrap,
   input wire logic [4:0] lockoutResIdx,
   input wire logic [15:0] inputVoltage,
   input wire logic [11:0] outputSenseMv,
   input wire logic [11:0] targetMv,
   input wire logic overcurrentDet,
   input wire logic signed [9:0] dieTemp,
   input wire logic extClockMode,
   // sequencing
   input wire logic enablePin,
   input wire logic rampDone,
   // outputs to power stage
   output logic highSideEn,
   output logic lowSideEn,
   output logic powerGoodOutput,
   output logic rampStart,
   output logic [11:0] refStartMv,
   output logic prebiasHigh
);

   //////////////////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic ack_r;
   logic [31:0] readdata_r;
   logic [2:0] ctrl_r;
   logic restart_r;
   logic [15:0] uvth_r;
   logic [15:0] resp_r;
   logic [7:0] ovPct_r;
   logic signed [9:0] otLim_r;
   logic [15:0] delay_r;
   pfpm_state_t state_r;
   logic [1:0] cause_r;
   logic pg_r;
   logic rampStart_r;
   logic [11:0] refStart_r;
   logic prebiasHigh_r;
   logic [15:0] tickCnt_r;
   logic tick;
   logic [7:0] waitCnt_r;
   logic [7:0] dlyCnt_r [NFAULT];
   logic [RETRY_W-1:0] retryCnt_r [NFAULT];
   logic [NFAULT-1:0] active;
   logic [NFAULT-1:0] trip;
   pfpm_resp_t effResp [NFAULT];
   logic [15:0] lockoutThreshold;
   logic [20:0] senseScaled;
   logic [20:0] limitScaled;
   logic signed [10:0] otCoolLevel;
   logic ovActive;
   logic causeClear;
   logic waitDone;
   logic runReq;
   logic wrEn;
   logic pgRise;
   pfpm_resp_t causeResp;

   function automatic logic [1:0] firstSet(input logic [NFAULT-1:0] v);
      logic [1:0] idx;
      idx = 2'(NFAULT - 1);
      for (int i = NFAULT - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 2'(i);
         end
      end
      return idx;
   endfunction

   // unknown codes fall back to the default; low-side hold is overvoltage only
   function automatic pfpm_resp_t legalResp(input int f, input logic [2:0] code,
                                            input logic extClk);
      pfpm_resp_t r;
      r = (code > 3'h5) ? RSP_SHUT_AUTO : pfpm_resp_t'(code);
      if (r == RSP_LOWSIDE && (f != F_OV || extClk)) begin
         r = RSP_SHUT_AUTO; // R9
      end
      return r;
   endfunction

   //////////////////////////////////////////////////////////////////////////////////////////////
   // register bus: one wait state, answer on the second cycle of a request
   assign waitrequest = (read | write) & ~ack_r;
   assign wrEn = write & ack_r;
   assign readdata = readdata_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (read | write) & ~ack_r;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         readdata_r <= 32'h0;
      end else if (read && !ack_r) begin
         unique case (address)
            OFS_CTRL: readdata_r <= {29'h0, ctrl_r};
            OFS_UVTH: readdata_r <= {16'h0, uvth_r};
            OFS_RESP: readdata_r <= {16'h0, resp_r};
            OFS_OVPCT: readdata_r <= {24'h0, ovPct_r};
            OFS_OTLIM: readdata_r <= {{22{otLim_r[9]}}, otLim_r};
            OFS_DELAY: readdata_r <= {16'h0, delay_r};
            OFS_STATUS: readdata_r <= {22'h0, cause_r, active, powerGoodOutput, state_r};
            OFS_THUSED: readdata_r <= {16'h0, lockoutThreshold};
            default: readdata_r <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_r <= CTRL_RST;
         restart_r <= 1'b0;
      end else begin
         restart_r <= wrEn && address == OFS_CTRL && writedata[CTRL_RESTART_BIT];
         if (wrEn && address == OFS_CTRL) begin
            ctrl_r <= {writedata[CTRL_UVSW_BIT], 1'b0, writedata[CTRL_EN_BIT]};
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         uvth_r <= UVTH_RST;
         resp_r <= RESP_RST;
         ovPct_r <= OVPCT_RST;
         otLim_r <= OTLIM_RST;
         delay_r <= DELAY_RST;
      end else if (wrEn) begin
         if (address == OFS_UVTH) begin
            // out-of-range writes are clamped to the usable span
            if (writedata[15:0] < UV_MIN) begin
               uvth_r <= UV_MIN; // R2
            end else if (writedata[15:0] > UV_MAX) begin
               uvth_r <= UV_MAX; // R2
            end else begin
               uvth_r <= writedata[15:0]; // R2
            end
         end
         if (address == OFS_RESP) resp_r <= writedata[15:0];
         if (address == OFS_OVPCT) ovPct_r <= writedata[7:0];
         if (address == OFS_OTLIM) otLim_r <= writedata[9:0]; // R16
         if (address == OFS_DELAY) delay_r <= writedata[15:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////////
   // threshold selection and fault detection
   always_comb begin
      lockoutThreshold = UV_OPEN;
      if (ctrl_r[CTRL_UVSW_BIT]) begin
         lockoutThreshold = uvth_r; // R2
      end else begin
         unique case (pfpm_strap_t'(lockoutStrap))
            STRAP_LOW: lockoutThreshold = UV_LOW; // R1
            STRAP_OPEN: lockoutThreshold = UV_OPEN; // R1
            STRAP_HIGH: lockoutThreshold = UV_HIGH; // R1
            STRAP_RES: lockoutThreshold = (lockoutResIdx >= 5'(UV_RES_N)) ?
                       UV_RES_TBL[UV_RES_N-1] : UV_RES_TBL[lockoutResIdx]; // R3
         endcase
      end
   end

   assign senseScaled = 21'(outputSenseMv) * 21'd100;
   assign limitScaled = 21'(targetMv) * (21'd100 + 21'(ovPct_r));
   assign ovActive = senseScaled > limitScaled; // R6
   assign otCoolLevel = 11'(otLim_r) - OT_HYST;
   assign active = {dieTemp > otLim_r, overcurrentDet, ovActive, inputVoltage < lockoutThreshold};
   assign runReq = enablePin & ctrl_r[CTRL_EN_BIT];

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         tickCnt_r <= 16'h0;
      end else begin
         tickCnt_r <= tick ? 16'h0 : tickCnt_r + 16'h1;
      end
   end
   assign tick = tickCnt_r >= TICK_CYCLES_P - 16'h1;

   generate
      for (genvar f = 0; f < NFAULT; f++) begin : g_fault
         assign effResp[f] = legalResp(f, resp_r[f*RESP_W +: RESP_W], extClockMode);
         // delayed shutdown: run-time counted in ms while the fault persists
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               dlyCnt_r[f] <= 8'h0;
            end else if (!active[f] || !(state_r == ST_RAMP || state_r == ST_RUN)) begin
               dlyCnt_r[f] <= 8'h0;
            end else if (tick && dlyCnt_r[f] != 8'hff) begin
               dlyCnt_r[f] <= dlyCnt_r[f] + 8'h1;
            end
         end
         always_comb begin
            unique case (effResp[f])
               RSP_CONTINUE: trip[f] = 1'b0; // R4 R14 R17
               RSP_DELAY_LATCH: trip[f] = active[f] &&
                                  dlyCnt_r[f] >= delay_r[DLY_RUN_LSB +: 8]; // R4 R14 R17
               default: trip[f] = active[f]; // R5 R8 R15 R16 R19
            endcase
         end
         always_ff @(posedge clock) begin
            if (!rst_n) begin
               retryCnt_r[f] <= RESP_RST[RESP_RETRY_LSB +: RETRY_W];
            end else if (pgRise) begin
               retryCnt_r[f] <= resp_r[RESP_RETRY_LSB +: RETRY_W]; // R20
            end else if (state_r == ST_FAULT && cause_r == 2'(f) && waitDone && causeClear &&
                         retryCnt_r[f] != '0 && effResp[f] == RSP_RETRY_N) begin
               retryCnt_r[f] <= retryCnt_r[f] - 4'h1; // R4 R7 R14 R17
            end
         end
      end
   endgenerate

   //////////////////////////////////////////////////////////////////////////////////////////////
   // start-up and fault response sequencing
   assign causeResp = effResp[cause_r];
   assign waitDone = waitCnt_r >= delay_r[DLY_RETRY_LSB +: 8];
   // thermal retries demand the die to cool below the hysteresis level
   assign causeClear = (cause_r == 2'(F_OT) && causeResp != RSP_SHUT_AUTO) ?
                       (11'(dieTemp) < otCoolLevel) : !active[cause_r]; // R18 R19
   assign pgRise = state_r == ST_RAMP && runReq && trip == '0 && rampDone;

   always_ff @(posedge clock) begin
      if (!rst_n || state_r != ST_FAULT || (waitDone && causeClear)) begin
         waitCnt_r <= 8'h0;
      end else if (waitDone) begin
         waitCnt_r <= 8'h0; // R18
      end else if (tick) begin
         waitCnt_r <= waitCnt_r + 8'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= ST_OFF;
         cause_r <= 2'h0;
         refStart_r <= 12'h0;
         prebiasHigh_r <= 1'b0;
         rampStart_r <= 1'b0;
      end else begin
         rampStart_r <= 1'b0;
         unique case (state_r)
            ST_OFF: begin
               if (runReq && ovActive) begin
                  state_r <= ST_FAULT; // R13
                  cause_r <= 2'(F_OV); // R13
               end else if (runReq && !(active[F_UV] && effResp[F_UV] != RSP_CONTINUE)) begin
                  state_r <= ST_RAMP;
                  refStart_r <= outputSenseMv; // R10 R11
                  prebiasHigh_r <= outputSenseMv > targetMv; // R10 R12
                  rampStart_r <= 1'b1; // R11
               end
            end
            ST_RAMP, ST_RUN: begin
               if (trip != '0) begin
                  state_r <= ST_FAULT;
                  cause_r <= firstSet(trip);
               end else if (!runReq) begin
                  state_r <= ST_OFF;
               end else if (state_r == ST_RAMP && rampDone) begin
                  state_r <= ST_RUN; // R12
               end
            end
            ST_FAULT: begin
               if (!runReq) begin
                  state_r <= ST_OFF;
               end else if (causeResp == RSP_DELAY_LATCH) begin
                  state_r <= ST_LATCHED; // R4
               end else if (causeResp == RSP_SHUT_AUTO) begin
                  if (causeClear) state_r <= ST_OFF; // R5 R8 R15 R19
               end else if (waitDone && causeClear) begin
                  if (causeResp == RSP_RETRY_N && retryCnt_r[cause_r] == '0) begin
                     state_r <= ST_LATCHED; // R14
                  end else begin
                     state_r <= ST_OFF; // R7 R18
                  end
               end
            end
            ST_LATCHED: begin
               if (restart_r || !runReq) state_r <= ST_OFF; // R4
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pg_r <= 1'b0;
      end else if (pgRise) begin
         pg_r <= 1'b1; // R12
      end else if (state_r != ST_RUN || trip != '0 || !runReq) begin
         pg_r <= 1'b0;
      end
   end

   assign powerGoodOutput = pg_r & ~ovActive; // R6
   assign highSideEn = state_r == ST_RAMP || state_r == ST_RUN; // R11 R12
   assign lowSideEn = highSideEn ||
                      (state_r == ST_FAULT && cause_r == 2'(F_OV) && causeResp == RSP_LOWSIDE); // R7
   assign rampStart = rampStart_r;
   assign refStartMv = refStart_r;
   assign prebiasHigh = prebiasHigh_r;

   //////////////////////////////////////////////////////////////////////////////////////////////
   // assertions
   strap_low_a: assert property (@(posedge clock) disable iff (!rst_n)
      !ctrl_r[CTRL_UVSW_BIT] && lockoutStrap == 2'h0 |-> lockoutThreshold == UV_LOW) // R1
      else $error("strap low does not give 3 V");
   sw_thresh_a: assert property (@(posedge clock) disable iff (!rst_n)
      ctrl_r[CTRL_UVSW_BIT] |-> lockoutThreshold == uvth_r && uvth_r >= UV_MIN) // R2
      else $error("software threshold not applied");
   res_map_a: assert property (@(posedge clock) disable iff (!rst_n)
      !ctrl_r[CTRL_UVSW_BIT] && lockoutStrap == 2'h3 && lockoutResIdx == 5'h0a
      |-> lockoutThreshold == 16'h02e6) // R3
      else $error("resistor strap mapped wrongly");
   pg_ov_drop_a: assert property (@(posedge clock) disable iff (!rst_n)
      ovActive |-> !powerGoodOutput) // R6
      else $error("power good high during overvoltage");
   ov_shutdown_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_RUN && runReq && ovActive && effResp[F_OV] == RSP_SHUT_AUTO && !active[F_UV]
      |=> state_r == ST_FAULT && !highSideEn ##1 !highSideEn) // R8
      else $error("overvoltage did not shut down");
   lowside_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_FAULT && cause_r == 2'(F_OV) |->
      lowSideEn == (effResp[F_OV] == RSP_LOWSIDE) && !highSideEn) // R7
      else $error("low-side hold wrong");
   extclk_only_a: assert property (@(posedge clock) disable iff (!rst_n)
      extClockMode && state_r == ST_FAULT |-> !lowSideEn) // R9
      else $error("low-side hold used with external clock");
   prebias_ov_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_OFF && runReq && ovActive |=> state_r == ST_FAULT && cause_r == 2'(F_OV)
      && !highSideEn) // R13
      else $error("pre-bias above limit not refused");
   prebias_ref_a: assert property (@(posedge clock) disable iff (!rst_n)
      rampStart |-> refStartMv == $past(outputSenseMv) && highSideEn && lowSideEn) // R10 R11
      else $error("ramp not started at pre-bias level");
   pg_at_ramp_a: assert property (@(posedge clock) disable iff (!rst_n)
      pgRise && !ovActive |=> powerGoodOutput || ovActive) // R12
      else $error("power good missing after soft start");
   uv_ignore_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_RUN && runReq && trip == '0 |=> state_r == ST_RUN) // R4
      else $error("left run without a tripped fault");
   uv_auto_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_FAULT && runReq && cause_r == 2'(F_UV) && effResp[F_UV] == RSP_SHUT_AUTO
      && !active[F_UV] |=> state_r == ST_OFF) // R5
      else $error("undervoltage auto restart missed");
   ot_hyst_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_FAULT && runReq && cause_r == 2'(F_OT) && effResp[F_OT] == RSP_RETRY_INF
      && 11'(dieTemp) >= otCoolLevel |=> state_r == ST_FAULT) // R17 R18
      else $error("thermal restart above hysteresis level");
   ot_trip_a: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == ST_RUN && runReq && dieTemp > otLim_r && effResp[F_OT] == RSP_SHUT_AUTO
      |=> state_r == ST_FAULT) // R16 R19
      else $error("over-temperature did not shut down");
   retry_reload_a: assert property (@(posedge clock) disable iff (!rst_n)
      pgRise |=> retryCnt_r[F_OC] == $past(resp_r[15:12])) // R15 R20
      else $error("retry budget not reloaded");

endmodule

`default_nettype wire

// File: hw/pfpm_pkg.sv
// constants, register map and types of the power fault protection manager
package pfpm_pkg;

   // clock and timing
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_UVTH = 8'h04;
   localparam logic [7:0] OFS_RESP = 8'h08;
   localparam logic [7:0] OFS_OVPCT = 8'h0c;
   localparam logic [7:0] OFS_OTLIM = 8'h10;
   localparam logic [7:0] OFS_DELAY = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_THUSED = 8'h1c;

   // control fields
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_RESTART_BIT = 1;
   localparam int CTRL_UVSW_BIT = 2;

   // response fields: 3 bits per fault type, retry limit above
   localparam int RESP_W = 3;
   localparam int RESP_RETRY_LSB = 12;
   localparam int RETRY_W = 4;

   // delay fields, in ms ticks
   localparam int DLY_RETRY_LSB = 0;
   localparam int DLY_RUN_LSB = 8;

   // reset values
   localparam logic [2:0] CTRL_RST = 3'h1;
   localparam logic [15:0] UVTH_RST = 16'h01c2;
   localparam logic [15:0] RESP_RST = 16'h3000;
   localparam logic [7:0] OVPCT_RST = 8'h0f;
   localparam logic signed [9:0] OTLIM_RST = 10'sh07d;
   localparam logic [15:0] DELAY_RST = 16'h0a0a;

   // input lockout thresholds, 10 mV units
   localparam logic [15:0] UV_LOW = 16'h012c;
   localparam logic [15:0] UV_OPEN = 16'h01c2;
   localparam logic [15:0] UV_HIGH = 16'h0438;
   localparam logic [15:0] UV_MIN = 16'h011d;
   localparam logic [15:0] UV_MAX = 16'h0640;
   localparam int UV_RES_N = 19;
   localparam logic [15:0] UV_RES_TBL [0:18] = '{
      16'h011d, 16'h013a, 16'h0158, 16'h017b, 16'h01a2, 16'h01cb, 16'h01fa,
      16'h022d, 16'h0265, 16'h02a3, 16'h02e6, 16'h0332, 16'h0383, 16'h03de,
      16'h0442, 16'h04b0, 16'h0528, 16'h05ae, 16'h0640};

   // thermal restart hysteresis, degC
   localparam logic signed [10:0] OT_HYST = 11'sh00f;

   // fault type indices
   localparam int F_UV = 0;
   localparam int F_OV = 1;
   localparam int F_OC = 2;
   localparam int F_OT = 3;
   localparam int NFAULT = 4;

   typedef enum logic [1:0] {STRAP_LOW, STRAP_OPEN, STRAP_HIGH, STRAP_RES} pfpm_strap_t;

   typedef enum logic [2:0] {
      RSP_SHUT_AUTO, RSP_RETRY_INF, RSP_RETRY_N, RSP_DELAY_LATCH, RSP_CONTINUE, RSP_LOWSIDE
   } pfpm_resp_t;

   typedef enum logic [2:0] {ST_OFF, ST_RAMP, ST_RUN, ST_FAULT, ST_LATCHED} pfpm_state_t;

endpackage

// File: tb/pfpm_sensor_model.sv
// power stage, input supply and sensor model facing the fault manager
`timescale 1ns/1ns
`default_nettype none
module pfpm_sensor_model #(
   parameter int RAMP_CYCLES = 6
) (
   // clock
   input wire logic clock,
   // scenario settings
   input wire logic [15:0] vinSet,
   input wire logic [11:0] voutSet,
   input wire logic ocSet,
   input wire logic signed [9:0] tempSet,
   // power stage
   input wire logic highSideEn,
   input wire logic rampStart,
   output logic [15:0] inputVoltage,
   output logic [11:0] outputSenseMv,
   output logic overcurrentDet,
   output logic signed [9:0] dieTemp,
   output logic rampDone
);
   int rampCnt = 0;
   // sensors lag one cycle, as a real converter's sampling would
   always_ff @(posedge clock) begin
      inputVoltage <= vinSet;
      outputSenseMv <= voutSet;
      overcurrentDet <= ocSet;
      dieTemp <= tempSet;
   end
   // soft-start period expires a fixed span after the ramp begins
   always_ff @(posedge clock) begin
      if (rampStart) begin
         rampCnt <= RAMP_CYCLES;
      end else if (rampCnt > 0) begin
         rampCnt <= rampCnt - 1;
      end
      rampDone <= highSideEn && (rampCnt == 1);
   end
endmodule
`default_nettype wire

// File: tb/pfpm_manager_tb_top.sv
// self-checking testbench of the power fault protection manager
`timescale 1ns/1ns
`default_nettype none
module pfpm_manager_tb_top;
   import pfpm_pkg::*;
   logic clock = 0, rst_n = 0, read = 0, write = 0, waitrequest;
   logic [7:0] address = 8'h00;
   logic [31:0] writedata = 32'h0, readdata, rd;
   logic [1:0] lockoutStrap = 2'h1;
   logic [4:0] lockoutResIdx = 5'h00;
   logic [15:0] inputVoltage, vinSet = 16'h04b0;
   logic [11:0] outputSenseMv, voutSet = 12'h000, refStartMv;
   logic signed [9:0] dieTemp, tempSet = 10'sh019;
   logic overcurrentDet, ocSet = 0, extClockMode = 0, enablePin = 0, rampDone;
   logic highSideEn, lowSideEn, powerGoodOutput, rampStart, prebiasHigh;
   int mismatches = 0, n_compared = 0;
   pfpm_manager #(.TICK_CYCLES_P(16'h0004)) u_dut (.clock(clock), .rst_n(rst_n),
      .address(address), .read(read), .write(write), .writedata(writedata),
      .readdata(readdata), .waitrequest(waitrequest), .lockoutStrap(lockoutStrap),
      .lockoutResIdx(lockoutResIdx), .inputVoltage(inputVoltage),
      .outputSenseMv(outputSenseMv), .targetMv(12'h3e8), .overcurrentDet(overcurrentDet),
      .dieTemp(dieTemp), .extClockMode(extClockMode), .enablePin(enablePin),
      .rampDone(rampDone), .highSideEn(highSideEn), .lowSideEn(lowSideEn),
      .powerGoodOutput(powerGoodOutput), .rampStart(rampStart), .refStartMv(refStartMv),
      .prebiasHigh(prebiasHigh));
   pfpm_sensor_model u_model (.clock(clock), .vinSet(vinSet), .voutSet(voutSet),
      .ocSet(ocSet), .tempSet(tempSet), .highSideEn(highSideEn), .rampStart(rampStart),
      .inputVoltage(inputVoltage), .outputSenseMv(outputSenseMv),
      .overcurrentDet(overcurrentDet), .dieTemp(dieTemp), .rampDone(rampDone));
   initial begin
      forever #25 clock = ~clock;
   end
   //////////////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask
   // one bus cycle; request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 0;
      write <= 0;
      chk(n, 2);
   endtask
   task automatic endTest(input string name);
      $display("test %s done, %0d compared, %0d mismatches", name, n_compared, mismatches);
   endtask
   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // drop the run request, change the output sense, then ask again
   task automatic restartAt(input logic [11:0] mv);
      @(posedge clock) enablePin <= 0;
      @(posedge clock) voutSet <= mv;
      repeat (2) @(posedge clock);
      enablePin <= 1;
   endtask
   //////////////////////////////////////////////////////////////////////////////////////////
   logic [31:0] regOfs [7] = '{32'h00, 32'h04, 32'h08, 32'h0c, 32'h10, 32'h14, 32'h20};
   logic [31:0] regRst [7] = '{32'h1, 32'h1c2, 32'h3000, 32'h0f, 32'h7d, 32'h0a0a, 32'h0};
   logic [6:0] strapCase [5] = '{7'h00, 7'h20, 7'h40, 7'h6a, 7'h72};
   logic [15:0] strapExp [5] = '{16'h012c, 16'h01c2, 16'h0438, 16'h02e6, 16'h0640};
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1;
      for (int i = 0; i < 7; i++) begin
         bus(0, regOfs[i][7:0], 32'h0);
         chk(rd, regRst[i]);
      end
      endTest("reset values");
      for (int i = 0; i < 5; i++) begin
         @(posedge clock) {lockoutStrap, lockoutResIdx} <= strapCase[i];
         bus(0, 8'h1c, 32'h0);
         bus(0, 8'h1c, 32'h0);
         chk(rd, {16'h0, strapExp[i]});
      end
      // back to the open strap, so the 12 V input clears the lockout later on
      @(posedge clock) {lockoutStrap, lockoutResIdx} <= 7'h20;
      bus(1, 8'h04, 32'h300);
      bus(1, 8'h00, 32'h5);
      bus(0, 8'h1c, 32'h0);
      chk(rd, 32'h300);
      bus(1, 8'h04, 32'h100);
      bus(0, 8'h1c, 32'h0);
      chk(rd, 32'h11d);
      bus(1, 8'h00, 32'h1);
      endTest("threshold");
      restartAt(12'h1f4);
      cyc(3);
      chk({highSideEn, prebiasHigh, 18'h0, refStartMv}, {2'b10, 30'h1f4});
      cyc(10);
      chk(powerGoodOutput, 1);
      restartAt(12'h44c);
      cyc(3);
      chk({highSideEn, prebiasHigh}, 2'b11);
      cyc(10);
      chk(powerGoodOutput, 1);
      @(posedge clock) voutSet <= 12'h4b0;
      cyc(2);
      chk({powerGoodOutput, highSideEn}, 2'b00);
      @(posedge clock) voutSet <= 12'h3e8;
      cyc(14);
      chk(powerGoodOutput, 1);
      restartAt(12'h4b0);
      cyc(4);
      bus(0, 8'h18, 32'h0);
      cyc(0);
      chk({highSideEn, rd[2:0]}, {1'b0, 3'h3});
      @(posedge clock) voutSet <= 12'h3e8;
      cyc(14);
      endTest("pre-bias and overvoltage");
      @(posedge clock) vinSet <= 16'h0100;
      cyc(3);
      chk(highSideEn, 0);
      @(posedge clock) vinSet <= 16'h04b0;
      cyc(14);
      chk(powerGoodOutput, 1);
      @(posedge clock) ocSet <= 1;
      cyc(3);
      chk(highSideEn, 0);
      @(posedge clock) ocSet <= 0;
      cyc(14);
      chk(powerGoodOutput, 1);
      @(posedge clock) tempSet <= 10'sh07e;
      cyc(3);
      chk(highSideEn, 0);
      @(posedge clock) tempSet <= 10'sh07d;
      cyc(14);
      chk(powerGoodOutput, 1);
      endTest("default responses");
      bus(1, 8'h08, 32'h3028);
      @(posedge clock) voutSet <= 12'h4b0;
      cyc(3);
      chk({highSideEn, lowSideEn}, 2'b01);
      @(posedge clock) extClockMode <= 1;
      cyc(2);
      chk(lowSideEn, 0);
      endTest("low-side hold");
      @(posedge clock) voutSet <= 12'h3e8;
      bus(1, 8'h08, 32'h3200);
      cyc(14);
      @(posedge clock) tempSet <= 10'sh07e;
      cyc(3);
      // below the limit but above the cooled level: a retry must not restart yet
      @(posedge clock) tempSet <= 10'sh073;
      cyc(60);
      chk(highSideEn, 0);
      @(posedge clock) tempSet <= 10'sh064;
      cyc(70);
      chk(powerGoodOutput, 1);
      endTest("thermal retry");
      print_verdict;
   end
   initial begin
      repeat (5000) @(posedge clock);
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
